// ### pmu_regs_pkg.sv
// Register map constants of the power management control register bank.
// Shared by the bank, its assertion checker and its testbench.
package pmu_regs_pkg;
   localparam logic [7:0] SYSTEM_MONITOR_CTRL_OFS  = 8'h00;
   localparam logic [7:0] THERMAL_IRQ_CTRL_OFS     = 8'h01;
   localparam logic [7:0] BUCK1_VOLTAGE_SEL_OFS    = 8'h10;
   localparam logic [7:0] BUCK1_CONTROL_OFS        = 8'h12;
   localparam logic [7:0] BUCK2_VOLTAGE_SEL_OFS    = 8'h20;
   localparam logic [7:0] BUCK2_CONTROL_OFS        = 8'h22;
   localparam logic [7:0] KEEPALIVE_LDO_ENABLE_OFS = 8'h91;
   localparam logic [7:0] CHARGER_CONFIG_OFS       = 8'hA1;
   localparam logic [7:0] CHARGER_STATUS_OFS       = 8'hA8;
   localparam logic [7:0] CHARGER_IRQ_CTRL_OFS     = 8'hA9;
   localparam logic [7:0] CHARGER_STATE_OFS        = 8'hAA;
   localparam logic [7:0] OTG_SWITCH_CTRL_OFS      = 8'hB0;
   localparam logic [7:0] OTG_IRQ_CTRL_OFS         = 8'hB2;
   localparam logic [7:0] IRQ_SOURCE_ADDRESS_OFS   = 8'hC1;

   // Bit positions.
   localparam int UNMASK_BIT    = 7;
   localparam int FLAG_BIT      = 6;
   localparam int BELOW_NOW_BIT = 5;
   localparam int THRESH_LSB    = 0;
   localparam int THRESH_W      = 4;
   localparam int LEVEL_LSB     = 0;
   localparam int LEVEL_W       = 6;
   localparam int ENABLE_BIT    = 7;
   localparam int PHASE_BIT     = 2;
   localparam int FAULT_UM_BIT  = 1;
   localparam int PGOOD_BIT     = 0;

   // Bits that software may change; all others ignore writes.
   localparam logic [7:0] SYS_WMASK       = 8'h8F;
   localparam logic [7:0] THERM_WMASK     = 8'h80;
   localparam logic [7:0] LEVEL_WMASK     = 8'h3F;
   localparam logic [7:0] BUCK_CTRL_WMASK = 8'h86;
   localparam logic [7:0] KEEPALIVE_WMASK = 8'hC0;
   localparam logic [7:0] CHG_CFG_WMASK   = 8'hBF;
   localparam logic [7:0] CHG_IRQ_WMASK   = 8'hFF;
   localparam logic [7:0] OTG_SW_WMASK    = 8'hE2;
   localparam logic [7:0] OTG_IRQ_WMASK   = 8'hCE;

   // Reset values of the stored bits.
   localparam logic [7:0] SYS_RST         = 8'h00;
   localparam logic [7:0] THERM_RST       = 8'h00;
   localparam logic [7:0] BUCK1_LEVEL_RST = 8'h18;
   localparam logic [7:0] BUCK2_LEVEL_RST = 8'h39;
   localparam logic [7:0] BUCK1_CTRL_RST  = 8'h80;
   localparam logic [7:0] BUCK2_CTRL_RST  = 8'h84;
   localparam logic [7:0] KEEPALIVE_RST   = 8'h80;
   localparam logic [7:0] CHG_CFG_RST     = 8'h28;
   localparam logic [7:0] CHG_IRQ_RST     = 8'h00;
   localparam logic [7:0] OTG_SW_RST      = 8'h20;
   localparam logic [7:0] OTG_IRQ_RST     = 8'h00;

   localparam int NUM_BUCKS = 2;
endpackage

// ### pmu_control_register_bank.sv
// Control and status register bank of the power management unit.
// Assumes a serial bus engine on clk that issues one-cycle read and write
// strobes with an 8-bit address; analog status levels arrive asynchronously.
`timescale 1ns/1ns

// Operation
// R1 - System register bit 7 is writable supply-level interrupt unmask.
// R2 - System register bit 6 reads 1 once a supply-level interrupt occurred.
// R3 - System register bit 5 shows live supply-below-threshold comparison.
// R4 - System register bits 3:0 hold the writable supply threshold select.
// R5 - Thermal register bit 7 is writable thermal interrupt unmask.
// R6 - Thermal register bit 6 reads 1 once a thermal interrupt occurred.
// R7 - Each buck has a writable six-bit output level; bits 7:6 reserved.
// R8 - Buck control bit 7 enables the regulator when 1.
// R9 - Buck control bit 2 selects 180 degree phase when 1, in phase when 0.
// R10 - Buck control bit 1 lets that buck's fault raise an interrupt.
// R11 - Buck control bit 0 reads 1 while output is above power-good level.
// R12 - Software should keep reserved bits at their default values.
// R13 - Writes to read-only and reserved bits are ignored.
// R14 - Interrupt request rises whenever an active status meets its set unmask; only supply, thermal and buck fault sources feed irq_request,
// the charger and OTG interrupt control bits do not.
module pmu_control_register_bank (
   input  wire logic                                    clk,
   input  wire logic                                    arst_n,
   input  wire logic [7:0]                              reg_addr,
   input  wire logic                                    reg_wr_en,
   input  wire logic [7:0]                              reg_wr_data,
   input  wire logic                                    reg_rd_en,
   output logic      [7:0]                              reg_rd_data,
   input  wire logic                                    supply_below_threshold_now,
   input  wire logic                                    thermal_alarm,
   input  wire logic [pmu_regs_pkg::NUM_BUCKS-1:0]      buck_power_good,
   input  wire logic [pmu_regs_pkg::NUM_BUCKS-1:0]      buck_fault,
   input  wire logic [7:0]                              charger_status_in,
   input  wire logic [7:0]                              charger_state_in,
   input  wire logic [7:0]                              otg_status_in,
   input  wire logic [7:0]                              irq_source_in,
   output logic [pmu_regs_pkg::THRESH_W-1:0]            supply_threshold_sel,
   output logic [pmu_regs_pkg::NUM_BUCKS-1:0][5:0]      output_level_sel,
   output logic [pmu_regs_pkg::NUM_BUCKS-1:0]           buck_enable,
   output logic [pmu_regs_pkg::NUM_BUCKS-1:0]           buck_phase_180,
   output logic [7:0]                                   keepalive_ldo_enable,
   output logic [7:0]                                   charger_config,
   output logic [7:0]                                   charger_irq_ctrl,
   output logic [7:0]                                   otg_switch_ctrl,
   output logic [7:0]                                   otg_irq_ctrl,
   output logic                                         irq_request
);

   // Analog levels cross into clk through two flip-flops each.
   localparam int SYNC_W = 2 + 2 * pmu_regs_pkg::NUM_BUCKS;

   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;

   assign async_in = {buck_fault, buck_power_good, thermal_alarm, supply_below_threshold_now};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   logic                                below_now;
   logic                                thermal_now;
   logic [pmu_regs_pkg::NUM_BUCKS-1:0]  pgood_now;
   logic [pmu_regs_pkg::NUM_BUCKS-1:0]  fault_now;

   assign below_now   = sync2_q[0];
   assign thermal_now = sync2_q[1];
   assign pgood_now   = sync2_q[2 +: pmu_regs_pkg::NUM_BUCKS];
   assign fault_now   = sync2_q[2 + pmu_regs_pkg::NUM_BUCKS +: pmu_regs_pkg::NUM_BUCKS];

   // Address decode.
   logic wr_sys;
   logic wr_therm;
   logic wr_keep;
   logic wr_chg_cfg;
   logic wr_chg_irq;
   logic wr_otg_sw;
   logic wr_otg_irq;
   logic rd_sys;
   logic rd_therm;

   assign wr_sys     = reg_wr_en && (reg_addr == pmu_regs_pkg::SYSTEM_MONITOR_CTRL_OFS);
   assign wr_therm   = reg_wr_en && (reg_addr == pmu_regs_pkg::THERMAL_IRQ_CTRL_OFS);
   assign wr_keep    = reg_wr_en && (reg_addr == pmu_regs_pkg::KEEPALIVE_LDO_ENABLE_OFS);
   assign wr_chg_cfg = reg_wr_en && (reg_addr == pmu_regs_pkg::CHARGER_CONFIG_OFS);
   assign wr_chg_irq = reg_wr_en && (reg_addr == pmu_regs_pkg::CHARGER_IRQ_CTRL_OFS);
   assign wr_otg_sw  = reg_wr_en && (reg_addr == pmu_regs_pkg::OTG_SWITCH_CTRL_OFS);
   assign wr_otg_irq = reg_wr_en && (reg_addr == pmu_regs_pkg::OTG_IRQ_CTRL_OFS);
   assign rd_sys     = reg_rd_en && (reg_addr == pmu_regs_pkg::SYSTEM_MONITOR_CTRL_OFS);
   assign rd_therm   = reg_rd_en && (reg_addr == pmu_regs_pkg::THERMAL_IRQ_CTRL_OFS);

   // Only masked bits take the written value; the rest keep their state.
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wdata, input logic [7:0] wmask);
      merge = (old & ~wmask) | (wdata & wmask);
   endfunction

   logic [7:0] sys_q;
   logic [7:0] sys_d;
   logic [7:0] therm_q;
   logic [7:0] therm_d;
   logic [7:0] keep_q;
   logic [7:0] chg_cfg_q;
   logic [7:0] chg_irq_q;
   logic [7:0] otg_sw_q;
   logic [7:0] otg_irq_q;

   assign sys_d   = wr_sys ? merge(sys_q, reg_wr_data, pmu_regs_pkg::SYS_WMASK) : sys_q;  // R1 R4 R13
   assign therm_d = wr_therm ? merge(therm_q, reg_wr_data, pmu_regs_pkg::THERM_WMASK) : therm_q;  // R5 R13

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sys_q     <= pmu_regs_pkg::SYS_RST;
         therm_q   <= pmu_regs_pkg::THERM_RST;
         keep_q    <= pmu_regs_pkg::KEEPALIVE_RST;
         chg_cfg_q <= pmu_regs_pkg::CHG_CFG_RST;
         chg_irq_q <= pmu_regs_pkg::CHG_IRQ_RST;
         otg_sw_q  <= pmu_regs_pkg::OTG_SW_RST;
         otg_irq_q <= pmu_regs_pkg::OTG_IRQ_RST;
      end else begin
         sys_q     <= sys_d;
         therm_q   <= therm_d;
         keep_q    <= wr_keep ? merge(keep_q, reg_wr_data, pmu_regs_pkg::KEEPALIVE_WMASK) : keep_q;
         chg_cfg_q <= wr_chg_cfg ? merge(chg_cfg_q, reg_wr_data, pmu_regs_pkg::CHG_CFG_WMASK) : chg_cfg_q;
         chg_irq_q <= wr_chg_irq ? merge(chg_irq_q, reg_wr_data, pmu_regs_pkg::CHG_IRQ_WMASK) : chg_irq_q;
         otg_sw_q  <= wr_otg_sw ? merge(otg_sw_q, reg_wr_data, pmu_regs_pkg::OTG_SW_WMASK) : otg_sw_q;
         otg_irq_q <= wr_otg_irq ? merge(otg_irq_q, reg_wr_data, pmu_regs_pkg::OTG_IRQ_WMASK) : otg_irq_q;
      end
   end

   // Sticky event flags: a read of the owning register clears them, but an
   // event present in the clearing cycle keeps the flag set so none is lost.
   logic supply_level_irq_flag_q;
   logic supply_level_irq_flag_d;
   logic thermal_irq_flag_q;
   logic thermal_irq_flag_d;

   assign supply_level_irq_flag_d = below_now | (supply_level_irq_flag_q & ~rd_sys);  // R2
   assign thermal_irq_flag_d      = thermal_now | (thermal_irq_flag_q & ~rd_therm);  // R6

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         supply_level_irq_flag_q <= 1'b0;
         thermal_irq_flag_q      <= 1'b0;
      end else begin
         supply_level_irq_flag_q <= supply_level_irq_flag_d;
         thermal_irq_flag_q      <= thermal_irq_flag_d;
      end
   end

   // Per-buck level and control storage.
   logic [pmu_regs_pkg::NUM_BUCKS-1:0][7:0] level_q;
   logic [pmu_regs_pkg::NUM_BUCKS-1:0][7:0] ctrl_q;
   logic [pmu_regs_pkg::NUM_BUCKS-1:0][7:0] ctrl_view;
   logic [pmu_regs_pkg::NUM_BUCKS-1:0]      fault_irq;

   localparam logic [pmu_regs_pkg::NUM_BUCKS-1:0][7:0] LEVEL_OFS = {pmu_regs_pkg::BUCK2_VOLTAGE_SEL_OFS,
                                                                      pmu_regs_pkg::BUCK1_VOLTAGE_SEL_OFS};
   localparam logic [pmu_regs_pkg::NUM_BUCKS-1:0][7:0] CTRL_OFS  = {pmu_regs_pkg::BUCK2_CONTROL_OFS,
                                                                      pmu_regs_pkg::BUCK1_CONTROL_OFS};
   localparam logic [pmu_regs_pkg::NUM_BUCKS-1:0][7:0] LEVEL_RST = {pmu_regs_pkg::BUCK2_LEVEL_RST,
                                                                      pmu_regs_pkg::BUCK1_LEVEL_RST};
   localparam logic [pmu_regs_pkg::NUM_BUCKS-1:0][7:0] CTRL_RST  = {pmu_regs_pkg::BUCK2_CTRL_RST,
                                                                      pmu_regs_pkg::BUCK1_CTRL_RST};

   genvar gi;
   generate
      for (gi = 0; gi < pmu_regs_pkg::NUM_BUCKS; gi++) begin : g_buck
         logic wr_level;
         logic wr_ctrl;

         assign wr_level = reg_wr_en && (reg_addr == LEVEL_OFS[gi]);
         assign wr_ctrl  = reg_wr_en && (reg_addr == CTRL_OFS[gi]);

         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               level_q[gi] <= LEVEL_RST[gi];
               ctrl_q[gi]  <= CTRL_RST[gi];
            end else begin
               level_q[gi] <= wr_level ? merge(level_q[gi], reg_wr_data, pmu_regs_pkg::LEVEL_WMASK) : level_q[gi];  // R7 R13
               ctrl_q[gi]  <= wr_ctrl ? merge(ctrl_q[gi], reg_wr_data, pmu_regs_pkg::BUCK_CTRL_WMASK) : ctrl_q[gi];  // R8 R9 R10 R13
            end
         end

         // The power-good bit is live status, never stored.
         assign ctrl_view[gi] = {ctrl_q[gi][7:1], pgood_now[gi]};  // R11
         assign fault_irq[gi] = fault_now[gi] & ctrl_q[gi][pmu_regs_pkg::FAULT_UM_BIT];  // R10

         assign output_level_sel[gi] = level_q[gi][pmu_regs_pkg::LEVEL_LSB +: pmu_regs_pkg::LEVEL_W];  // R7
         assign buck_enable[gi]      = ctrl_q[gi][pmu_regs_pkg::ENABLE_BIT];  // R8
         assign buck_phase_180[gi]   = ctrl_q[gi][pmu_regs_pkg::PHASE_BIT];  // R9
      end
   endgenerate

   // Read views with status bits spliced in.
   logic [7:0] sys_view;
   logic [7:0] therm_view;

   always_comb begin
      sys_view = sys_q;
      sys_view[pmu_regs_pkg::FLAG_BIT] = supply_level_irq_flag_q;  // R2
      sys_view[pmu_regs_pkg::BELOW_NOW_BIT] = below_now;  // R3
      therm_view = therm_q;
      therm_view[pmu_regs_pkg::FLAG_BIT] = thermal_irq_flag_q;  // R6
   end

   logic [7:0] rd_mux;

   always_comb begin
      unique case (reg_addr)
         pmu_regs_pkg::SYSTEM_MONITOR_CTRL_OFS:  rd_mux = sys_view;
         pmu_regs_pkg::THERMAL_IRQ_CTRL_OFS:     rd_mux = therm_view;
         pmu_regs_pkg::BUCK1_VOLTAGE_SEL_OFS:    rd_mux = level_q[0];
         pmu_regs_pkg::BUCK1_CONTROL_OFS:        rd_mux = ctrl_view[0];
         pmu_regs_pkg::BUCK2_VOLTAGE_SEL_OFS:    rd_mux = level_q[1];
         pmu_regs_pkg::BUCK2_CONTROL_OFS:        rd_mux = ctrl_view[1];
         pmu_regs_pkg::KEEPALIVE_LDO_ENABLE_OFS: rd_mux = keep_q;
         pmu_regs_pkg::CHARGER_CONFIG_OFS:       rd_mux = chg_cfg_q;
         pmu_regs_pkg::CHARGER_STATUS_OFS:       rd_mux = charger_status_in;
         pmu_regs_pkg::CHARGER_IRQ_CTRL_OFS:     rd_mux = chg_irq_q;
         pmu_regs_pkg::CHARGER_STATE_OFS:        rd_mux = charger_state_in;
         pmu_regs_pkg::OTG_SWITCH_CTRL_OFS:      rd_mux = otg_sw_q | (otg_status_in & ~pmu_regs_pkg::OTG_SW_WMASK);
         pmu_regs_pkg::OTG_IRQ_CTRL_OFS:         rd_mux = otg_irq_q;
         pmu_regs_pkg::IRQ_SOURCE_ADDRESS_OFS:   rd_mux = irq_source_in;
         default:                                rd_mux = 8'h00;
      endcase
   end

   // Read data is captured on the strobe and holds until the next read.
   logic [7:0] rd_data_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_q <= 8'h00;
      end else if (reg_rd_en) begin
         rd_data_q <= rd_mux;
      end
   end

   assign reg_rd_data = rd_data_q;

   // Fault interrupts are level requests; the event flags are sticky.
   logic irq_q;
   logic irq_d;

   assign irq_d = (supply_level_irq_flag_q & sys_q[pmu_regs_pkg::UNMASK_BIT])
                | (thermal_irq_flag_q & therm_q[pmu_regs_pkg::UNMASK_BIT])
                | (|fault_irq);  // R1 R5 R14

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign irq_request          = irq_q;
   assign supply_threshold_sel = sys_q[pmu_regs_pkg::THRESH_LSB +: pmu_regs_pkg::THRESH_W];  // R4
   assign keepalive_ldo_enable = keep_q;
   assign charger_config       = chg_cfg_q;
   assign charger_irq_ctrl     = chg_irq_q;
   assign otg_switch_ctrl      = otg_sw_q;
   assign otg_irq_ctrl         = otg_irq_q;

endmodule

// ### pmu_control_register_bank_sva.sv
// Assertion checker for the power management control register bank.
// Assumes it is bound to the bank and sees only its ports, on clk with arst_n.
`timescale 1ns/1ns
module pmu_bank_checker (
   input wire logic                                     clk,
   input wire logic                                     arst_n,
   input wire logic [7:0]                               reg_addr,
   input wire logic                                     reg_wr_en,
   input wire logic [7:0]                               reg_wr_data,
   input wire logic                                     reg_rd_en,
   input wire logic [7:0]                               reg_rd_data,
   input wire logic                                     supply_below_threshold_now,
   input wire logic                                     thermal_alarm,
   input wire logic [pmu_regs_pkg::NUM_BUCKS-1:0]       buck_power_good,
   input wire logic [pmu_regs_pkg::NUM_BUCKS-1:0]       buck_fault,
   input wire logic [pmu_regs_pkg::THRESH_W-1:0]        supply_threshold_sel,
   input wire logic [pmu_regs_pkg::NUM_BUCKS-1:0][5:0]  output_level_sel,
   input wire logic [pmu_regs_pkg::NUM_BUCKS-1:0]       buck_enable,
   input wire logic [pmu_regs_pkg::NUM_BUCKS-1:0]       buck_phase_180,
   input wire logic                                     irq_request
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire wr_sys   = reg_wr_en && reg_addr == 8'h00;
   wire wr_lvl1  = reg_wr_en && reg_addr == 8'h10;
   wire wr_ctl1  = reg_wr_en && reg_addr == 8'h12;
   wire wr_ctl2  = reg_wr_en && reg_addr == 8'h22;
   wire rd_sys   = reg_rd_en && reg_addr == 8'h00;
   wire rd_therm = reg_rd_en && reg_addr == 8'h01;
   wire rd_ctl1  = reg_rd_en && reg_addr == 8'h12;
   a_thresh_write: assert property (wr_sys |=> supply_threshold_sel == $past(reg_wr_data[3:0]))
      else $error("threshold select did not follow write");
   a_level_write: assert property (wr_lvl1 |=> output_level_sel[0] == $past(reg_wr_data[5:0]))
      else $error("output level did not follow write");
   a_enable_write: assert property (wr_ctl2 |=> buck_enable[1] == $past(reg_wr_data[7]))
      else $error("regulator enable did not follow write");
   a_phase_write: assert property (wr_ctl1 |=> buck_phase_180[0] == $past(reg_wr_data[2]))
      else $error("phase select did not follow write");
   a_below_live: assert property ((supply_below_threshold_now [*4] ##0 rd_sys) |=> reg_rd_data[5])
      else $error("live supply status not read as 1");
   a_pgood_read: assert property ((buck_power_good[0] [*4] ##0 rd_ctl1) |=> reg_rd_data[0])
      else $error("power good not read as 1");
   a_therm_flag: assert property ((thermal_alarm [*4] ##0 rd_therm) |=> reg_rd_data[6])
      else $error("thermal flag not read as 1");
   a_therm_resv: assert property (rd_therm |=> reg_rd_data[5:0] == 6'h00)
      else $error("reserved thermal bits read nonzero");
   a_fault_irq: assert property ((buck_fault[0] [*5] ##0 wr_ctl1 && reg_wr_data[1]) |=> ##[0:2] irq_request)
      else $error("unmasked fault raised no interrupt");
   c_irq: cover property ($rose(irq_request));
   c_therm: cover property (thermal_alarm [*4] ##0 rd_therm);
   c_wr_sys: cover property (wr_sys);
endmodule
bind pmu_control_register_bank pmu_bank_checker chk_i (.*);

// ### pmu_host_model.sv
// Host side model: issues one-cycle read and write strobes on the register port.
// Assumes the bank samples strobes on the rising edge of clk.
`timescale 1ns/1ns
module pmu_host_model (
   input  wire logic       clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr_en,
   output logic      [7:0] reg_wr_data,
   output logic            reg_rd_en,
   input  wire logic [7:0] reg_rd_data
);
   initial begin
      reg_addr    = 8'h00;
      reg_wr_en   = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en   = 1'b0;
   end
   // Released lines show the inverse so a stale value is never mistaken for data.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr    <= a;
      reg_wr_data <= d;
      reg_wr_en   <= 1'b1;
      @(posedge clk);
      reg_wr_en   <= 1'b0;
      reg_addr    <= ~a;
      reg_wr_data <= ~d;
      // Returning just after the edge lets the caller see outputs the write has already updated.
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      reg_addr  <= ~a;
      #1;
      d = reg_rd_data;
   endtask
endmodule

// ### test_pmu_control_register_bank.sv
// Self-checking testbench for the power management control register bank.
// Assumes the host model drives the register port and the bench drives status levels.
`timescale 1ns/1ns
module test_pmu_control_register_bank;
   logic                                    clk = 1'b0;
   logic                                    arst_n = 1'b0;
   logic [7:0]                              reg_addr, reg_wr_data, reg_rd_data, v;
   logic                                    reg_wr_en, reg_rd_en, irq_request;
   logic                                    below = 1'b0, therm = 1'b0;
   logic [1:0]                              pgood = 2'b00, fault = 2'b00, en, ph;
   logic [3:0]                              thr;
   logic [7:0]                              keep, chg_cfg, chg_irq, otg_sw, otg_irq;
   logic [pmu_regs_pkg::NUM_BUCKS-1:0][5:0] lvl;
   int                                      err_count = 0, checked = 0;
   pmu_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
      .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));
   pmu_control_register_bank dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
      .supply_below_threshold_now(below), .thermal_alarm(therm), .buck_power_good(pgood), .buck_fault(fault),
      .charger_status_in(8'hA5), .charger_state_in(8'h00), .otg_status_in(8'h00), .irq_source_in(8'h00),
      .supply_threshold_sel(thr), .output_level_sel(lvl), .buck_enable(en), .buck_phase_180(ph),
      .keepalive_ldo_enable(keep), .charger_config(chg_cfg), .charger_irq_ctrl(chg_irq),
      .otg_switch_ctrl(otg_sw), .otg_irq_ctrl(otg_irq),
      .irq_request(irq_request));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, v);
      cmp(v, exp);
   endtask
   task automatic wait_irq(input logic exp);
      int n;
      for (n = 0; n < 10 && irq_request !== exp; n++) begin
         @(posedge clk);
         #1;
      end
      cmp({7'h00, irq_request}, {7'h00, exp});
      if (irq_request !== exp) complete_run();
   endtask
   task automatic t_reset;
      logic [7:0] a[8] = '{8'h00, 8'h01, 8'h10, 8'h12, 8'h20, 8'h22, 8'h91, 8'h05};
      logic [7:0] e[8] = '{8'h00, 8'h00, 8'h18, 8'h80, 8'h39, 8'h84, 8'h80, 8'h00};
      foreach (a[i]) rchk(a[i], e[i]);
      rchk(8'hA8, 8'hA5);
      cmp({7'h00, irq_request}, 8'h00);
      cmp(keep, 8'h80);
      cmp(chg_cfg, 8'h28);
      cmp(chg_irq, 8'h00);
      cmp(otg_sw, 8'h20);
      cmp(otg_irq, 8'h00);
      host.wr(8'h91, 8'hFF);
      cmp(keep, 8'hC0);
      host.wr(8'hB2, 8'hFF);
      cmp(otg_irq, 8'hCE);
      host.wr(8'hB0, 8'h00);
      rchk(8'hB0, 8'h00);
      cmp(otg_sw, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_sys;
      host.wr(8'h00, 8'hFF);
      rchk(8'h00, 8'h8F);
      cmp({4'h0, thr}, 8'h0F);
      host.wr(8'h00, 8'h7A);
      rchk(8'h00, 8'h0A);
      host.wr(8'h01, 8'h7F);
      rchk(8'h01, 8'h00);
      $display("test system done");
   endtask
   task automatic t_buck;
      host.wr(8'h10, 8'hFF);
      rchk(8'h10, 8'h3F);
      cmp({2'b00, lvl[0]}, 8'h3F);
      host.wr(8'h22, 8'h06);
      rchk(8'h22, 8'h06);
      cmp({6'h00, en}, 8'h01);
      host.wr(8'h12, 8'h84);
      cmp({6'h00, ph}, 8'h03);
      $display("test buck done");
   endtask
   task automatic t_status;
      @(posedge clk);
      below <= 1'b1;
      therm <= 1'b1;
      pgood <= 2'b11;
      repeat (5) @(posedge clk);
      rchk(8'h00, 8'h6A);
      rchk(8'h01, 8'h40);
      rchk(8'h12, 8'h85);
      cmp({7'h00, irq_request}, 8'h00);
      @(posedge clk);
      below <= 1'b0;
      therm <= 1'b0;
      repeat (5) @(posedge clk);
      rchk(8'h00, 8'h4A);
      rchk(8'h00, 8'h0A);
      $display("test status done");
   endtask
   task automatic t_irq;
      @(posedge clk);
      therm <= 1'b1;
      host.wr(8'h01, 8'h80);
      wait_irq(1'b1);
      host.wr(8'h01, 8'h00);
      @(posedge clk);
      therm <= 1'b0;
      rchk(8'h01, 8'h40);
      wait_irq(1'b0);
      @(posedge clk);
      fault <= 2'b01;
      repeat (5) @(posedge clk);
      host.wr(8'h12, 8'h86);
      wait_irq(1'b1);
      @(posedge clk);
      fault <= 2'b00;
      wait_irq(1'b0);
      $display("test interrupt done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_sys();
      t_buck();
      t_status();
      t_irq();
      complete_run();
   end
endmodule
